// file: inc/itt_pkg.sv
/*
 * Constants shared by the interval / time-base timer: register offsets,
 * field positions, reset values and prescaler tap tables.
 * Assumes a 32-bit classic Wishbone slave with byte addresses.
 */
package itt_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int unsigned ITT_WB_AW       = 4;
    localparam logic [3:0]  ITT_OFS_MODE    = 4'h0;
    localparam logic [3:0]  ITT_OFS_COUNT   = 4'h4;
    localparam logic [3:0]  ITT_OFS_STATUS  = 4'h8;
    localparam logic [3:0]  ITT_OFS_MASK    = 4'hC;

    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam int unsigned ITT_SRC_BIT     = 3;
    localparam int unsigned ITT_SEL2_BIT    = 2;
    localparam int unsigned ITT_OVF_BIT     = 0;
    localparam logic [3:0]  ITT_MODE_RST    = 4'h0;
    localparam logic [3:0]  ITT_MODE_RSV    = 4'hF;
    localparam logic [7:0]  ITT_COUNT_RST   = 8'h00;
    localparam logic [7:0]  ITT_COUNT_MAX   = 8'hFF;
    localparam logic [0:0]  ITT_STATUS_RST  = 1'h0;
    localparam logic [0:0]  ITT_MASK_RST    = 1'h0;

    // ************************************************************
    // Prescalers
    // ************************************************************
    localparam int unsigned ITT_SYS_PS_W    = 13;
    localparam int unsigned ITT_SUB_PS_W    = 5;
    // Divide ratio exponent per clock select code 0..7
    localparam logic [3:0]  ITT_SYS_TAP [8] = '{4'hD, 4'hC, 4'hB, 4'h9,
                                                4'h8, 4'h7, 4'h5, 4'h3};
    // Subclock divide exponent per period code 2 s, 1 s, 0.5 s, 125 ms
    localparam logic [3:0]  ITT_SUB_TAP [4] = '{4'h5, 4'h4, 4'h3, 4'h1};

endpackage : itt_pkg

// file: inc/itt_pre_if.sv
/*
 * Carrier between the timer core and one prescaler counter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface itt_pre_if #(parameter int unsigned W = 13);
    logic         clr;
    logic         en;
    logic [W-1:0] cnt;
    modport ctl (output clr, output en, input cnt);
    modport pre (input clr, input en, output cnt);
endinterface : itt_pre_if

// file: src/itt_prescaler.sv
/*
 * Free-running binary prescaler with synchronous clear and count enable.
 * Assumes the controlling end drives clr and en from clk_sys logic.
 */
`timescale 1ns/10ps
module itt_prescaler #(
    parameter int unsigned W = 13
) (
    input  wire logic clk_sys, // System clock
    input  wire logic rstn,    // Async reset, active low
    itt_pre_if.pre    p        // Control and count
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (p.clr) begin
            cnt_nxt = '0;
        end else if (p.en) begin
            cnt_nxt = cnt_r + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign p.cnt = cnt_r;

endmodule : itt_prescaler

// file: src/itt_timer.sv
/*
 * Interval / time-base timer: 8-bit up-counter fed either by a tap of the
 * system-clock prescaler or by the subclock prescaler, with an overflow
 * request flag, an interrupt mask and a classic Wishbone register slave.
 * Assumes the subclock arrives as an asynchronous pin far slower than
 * clk_sys, and that sys_halt comes from power control logic on clk_sys.
 */
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/10ps

module itt_timer (
    input  wire logic                          clk_sys,   // System clock 10 MHz
    input  wire logic                          rstn,      // Async reset, active low
    input  wire logic                          sub_clk,   // Subclock pin, async
    input  wire logic                          sys_halt,  // System clock halted
    input  wire logic                          wb_cyc_i,  // Wishbone cycle
    input  wire logic                          wb_stb_i,  // Wishbone strobe
    input  wire logic                          wb_we_i,   // Wishbone write enable
    input  wire logic [itt_pkg::ITT_WB_AW-1:0] wb_adr_i,  // Wishbone byte address
    input  wire logic [3:0]                    wb_sel_i,  // Wishbone byte selects
    input  wire logic [31:0]                   wb_dat_i,  // Wishbone write data
    output logic      [31:0]                   wb_dat_o,  // Wishbone read data
    output logic                               wb_ack_o,  // Wishbone acknowledge
    output logic                               irq_o      // Overflow interrupt, level
);
    import itt_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [2:0]  sub_sync_r;
    logic [2:0]  sub_sync_nxt;
    logic        sub_lvl_r;
    logic        sub_lvl_nxt;
    logic        sub_rise;

    logic [3:0]  mode_r;
    logic [3:0]  mode_nxt;
    logic [7:0]  count_r;
    logic [7:0]  count_nxt;
    logic [0:0]  status_r;
    logic [0:0]  status_nxt;
    logic [0:0]  mask_r;
    logic [0:0]  mask_nxt;
    logic        irq_r;
    logic        irq_nxt;

    logic        ack_r;
    logic        ack_nxt;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;

    logic        req;
    logic        req_end;
    logic        rd_status;
    logic        wr_mode;
    logic        wr_mask;
    logic [0:0]  status_clr;
    logic        stop;
    logic        tick;
    logic        overflow;

    itt_pre_if #(.W(ITT_SYS_PS_W)) sys_ps ();
    itt_pre_if #(.W(ITT_SUB_PS_W)) sub_ps ();

    // ************************************************************
    // Helpers
    // ************************************************************
    // True when the low e bits of c are all ones: the tick of a 2^e divider
    // An e of 13 gives the full wrap of the system prescaler
    function automatic logic tap_hit(input logic [12:0] c, input logic [3:0] e);
        logic [12:0] m;
        m = (13'h0001 << e) - 13'h0001;
        return &(c | ~m);
    endfunction : tap_hit

    // ************************************************************
    // Subclock pin synchroniser
    // ************************************************************
    // Stage 0 feeds only stage 1; the level moves once stages 1 and 2 agree.
    // Subclock levels shorter than two clk_sys cycles are lost, so the pin
    // must stay far slower than clk_sys
    always_comb begin
        sub_sync_nxt = {sub_sync_r[1:0], sub_clk};
        sub_lvl_nxt  = sub_lvl_r;
        if (sub_sync_r[1] == sub_sync_r[2]) begin
            sub_lvl_nxt = sub_sync_r[2];
        end
    end

    // One enable pulse per settled rising edge
    assign sub_rise = (sub_sync_r[1] == sub_sync_r[2]) && sub_sync_r[2] && !sub_lvl_r;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sub_sync_r <= 3'h0;
            sub_lvl_r  <= 1'b0;
        end else begin
            sub_sync_r <= sub_sync_nxt;
            sub_lvl_r  <= sub_lvl_nxt;
        end
    end

    // ************************************************************
    // Prescalers
    // ************************************************************
    // Held clear for as long as the code stands, not only on the write
    assign stop = mode_r[ITT_SRC_BIT] && mode_r[ITT_SEL2_BIT];

    // No software path reaches this count
    // Cleared while halted, standing in for the stopped system clock
    assign sys_ps.clr = sys_halt;
    assign sys_ps.en  = 1'b1;

    // Counts on subclock edges whatever the system power state
    assign sub_ps.clr = stop;
    assign sub_ps.en  = sub_rise;

    itt_prescaler #(.W(ITT_SYS_PS_W)) u_sys_ps (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .p       (sys_ps)
    );

    itt_prescaler #(.W(ITT_SUB_PS_W)) u_sub_ps (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .p       (sub_ps)
    );

    // ************************************************************
    // Tick selection
    // ************************************************************
    // The system prescaler is never cleared by a mode write, so the first
    // interval tick after leaving the cleared state comes at a varying delay.
    // Time base: one tick per 2^e settled subclock edges and 256 ticks per
    // overflow, so the period code sets the interval in powers of two
    always_comb begin
        tick = 1'b0;
        if (stop) begin
            tick = 1'b0;
        end else if (!mode_r[ITT_SRC_BIT]) begin
            tick = !sys_halt && tap_hit(sys_ps.cnt, ITT_SYS_TAP[mode_r[2:0]]);
        end else begin
            tick = sub_rise && tap_hit({8'hFF, sub_ps.cnt}, ITT_SUB_TAP[mode_r[1:0]]);
        end
    end

    // One flag serves both modes
    assign overflow = tick && (count_r == ITT_COUNT_MAX);

    // ************************************************************
    // Counter
    // ************************************************************
    // Stop wins over a tick, so a 1,1 write clears even mid-count
    always_comb begin
        count_nxt = count_r;
        if (stop) begin
            count_nxt = ITT_COUNT_RST;
        end else if (tick) begin
            count_nxt = count_r + 8'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            count_r <= ITT_COUNT_RST;
        end else begin
            count_r <= count_nxt;
        end
    end

    // ************************************************************
    // Wishbone slave
    // ************************************************************
    // Ack comes one cycle after the request is seen and drops the next cycle.
    // Writes and read side effects land on the edge where the master sees ack.

    // Register map, all in byte lane 0, upper 24 bits read as zero:
    //   0x0 mode     [7:4] read as ones, [3] source, [2:0] clock select
    //   0x4 count    read only, writes dropped
    //   0x8 status   [0] overflow flag, cleared by the read that returns it
    //   0xC mask     [0] interrupt enable for the overflow flag
    // Unmapped offsets read zero and are still acknowledged so the
    // master never hangs on a stray address
    assign req     = wb_cyc_i && wb_stb_i && !ack_r;
    assign req_end = wb_cyc_i && wb_stb_i && ack_r;
    assign wr_mode = req_end && wb_we_i && wb_sel_i[0] && (wb_adr_i == ITT_OFS_MODE);
    assign wr_mask = req_end && wb_we_i && wb_sel_i[0] && (wb_adr_i == ITT_OFS_MASK);

    // Clear only what was actually returned, so a flag set after the data
    // was sampled survives the read
    assign rd_status  = req_end && !wb_we_i && (wb_adr_i == ITT_OFS_STATUS);
    assign status_clr = rd_status ? dat_r[ITT_OVF_BIT] : 1'b0;

    always_comb begin
        ack_nxt = req;
        dat_nxt = dat_r;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                ITT_OFS_MODE: begin
                    dat_nxt = {24'h000000, ITT_MODE_RSV, mode_r};
                end
                ITT_OFS_COUNT: begin
                    dat_nxt = {24'h000000, count_r};
                end
                ITT_OFS_STATUS: begin
                    dat_nxt = {31'h00000000, status_r};
                end
                ITT_OFS_MASK: begin
                    dat_nxt = {31'h00000000, mask_r};
                end
                default: begin
                    dat_nxt = 32'h00000000;
                end
            endcase
        end else if (req) begin
            // A write answers with zero data
            dat_nxt = 32'h00000000;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    // ************************************************************
    // Mode and mask registers
    // ************************************************************
    // Only byte lane 0 carries writable bits; other lanes are ignored.
    // A mode write lands at the ack edge; a tick in that cycle uses the old mode
    always_comb begin
        mode_nxt = mode_r;
        mask_nxt = mask_r;
        if (wr_mode) begin
            mode_nxt = wb_dat_i[3:0];
        end
        if (wr_mask) begin
            mask_nxt = wb_dat_i[ITT_OVF_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mode_r <= ITT_MODE_RST;
            mask_r <= ITT_MASK_RST;
        end else begin
            mode_r <= mode_nxt;
            mask_r <= mask_nxt;
        end
    end

    // ************************************************************
    // Request flag and interrupt
    // ************************************************************
    // The level is computed from next values so it moves on the same
    // edge as the flag or the mask, never a cycle late
    always_comb begin
        // Set wins over a clear in the same cycle
        status_nxt = (status_r & ~status_clr) | overflow;
        irq_nxt    = |(status_nxt & mask_nxt);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            status_r <= ITT_STATUS_RST;
            irq_r    <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq_r    <= irq_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // All three come straight from registers
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign irq_o    = irq_r;

endmodule : itt_timer

// file: test/itt_timer_asserts.sv
/* Checker for the timer register bus and interrupt output.
   Assumes it is bound to itt_timer and sees only its ports. */
`timescale 1ns/10ps
module itt_timer_asserts
    import itt_pkg::*;
(
    input wire logic                          clk_sys,  // Clock
    input wire logic                          rstn,     // Reset, active low
    input wire logic                          wb_cyc_i, // Cycle
    input wire logic                          wb_stb_i, // Strobe
    input wire logic                          wb_we_i,  // Write
    input wire logic [itt_pkg::ITT_WB_AW-1:0] wb_adr_i, // Address
    input wire logic [31:0]                   wb_dat_o, // Read data
    input wire logic                          wb_ack_o, // Acknowledge
    input wire logic                          irq_o     // Interrupt
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    logic rd_ack;
    assign rd_ack = wb_ack_o && !wb_we_i;
    a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    a_mode_ones: assert property (rd_ack && wb_adr_i == ITT_OFS_MODE |-> wb_dat_o[7:4] == 4'hF)
        else $error("mode high nibble wrong");
    a_unmapped_zero: assert property (rd_ack && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_status_bits: assert property (rd_ack && wb_adr_i == ITT_OFS_STATUS |-> wb_dat_o[7:1] == 7'h0)
        else $error("status spare bits set");
    a_irq_fall: assert property ($fell(irq_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("irq dropped without access");
endmodule : itt_timer_asserts

// file: test/itt_timer_tb.sv
/* Self-checking bench for itt_timer: registers, interval rates, halt,
   overflow interrupt, clear and time base. Assumes itt_pkg is compiled first. */
`timescale 1ns/10ps
module itt_timer_tb;
    import itt_pkg::*;
    logic        clk_sys, rstn, sub_clk, sys_halt, cyc, stb, we;
    logic [3:0]  adr, sel;
    logic [31:0] wdat, q, c0, wb_dat_o;
    logic        wb_ack_o, irq_o;
    int          fail_count = 0, check_count = 0, cyc_cnt = 0, sub_n = 0, t0;
    int          seed = 32'h80c2;
    int          div_tab[8] = '{8192, 4096, 2048, 512, 256, 128, 32, 8};
    int          sub_e[4] = '{5, 4, 3, 1};
    itt_timer dut (.clk_sys(clk_sys), .rstn(rstn), .sub_clk(sub_clk), .sys_halt(sys_halt),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
    // ****
    // Tasks
    // ****
    task automatic stop_test;
        $display("checks=%0d fails=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Holds the request until ack is seen at an edge
    // A lost ack is caught by the bench timeout, never by a local count
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_sys);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_sys);
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd
    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (irq_o !== 1'b1 && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
        chk({31'h0, irq_o}, 32'h1);
    endtask : wait_irq
    // ****
    // Clocks and timeout
    // ****
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Subclock period 40 system cycles, far slower than the sync
    always @(posedge clk_sys) begin
        cyc_cnt <= cyc_cnt + 1;
        sub_n <= (sub_n == 19) ? 0 : sub_n + 1;
        if (sub_n == 19)
            sub_clk <= ~sub_clk;
        if (cyc_cnt == 90000) begin
            fail_count++;
            stop_test();
        end
    end
    // ****
    // Main sequence
    // ****
    initial begin
        {rstn, sub_clk, sys_halt, cyc, stb, we, adr, wdat} = '0;
        sel = 4'hF;
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        rd(ITT_OFS_MODE, 32'hF0);
        rd(ITT_OFS_COUNT, 32'h0);
        rd(ITT_OFS_STATUS, 32'h0);
        rd(ITT_OFS_MASK, 32'h0);
        rd(4'h2, 32'h0);
        bus(1'b1, ITT_OFS_COUNT, $random(seed));
        rd(ITT_OFS_COUNT, 32'h0);
        sel <= 4'hE;
        bus(1'b1, ITT_OFS_MASK, 32'h1);
        sel <= 4'hF;
        rd(ITT_OFS_MASK, 32'h0);
        // Two tap periods between samples give exactly two ticks
        for (int s = 0; s < 8; s++) begin
            bus(1'b1, ITT_OFS_MODE, s);
            rd(ITT_OFS_MODE, 32'hF0 | s);
            t0 = cyc_cnt;
            bus(1'b0, ITT_OFS_COUNT, 32'h0);
            c0 = q;
            while (cyc_cnt < t0 + 2 * div_tab[s])
                @(posedge clk_sys);
            rd(ITT_OFS_COUNT, {24'h0, c0[7:0] + 8'h2});
        end
        sys_halt <= 1'b1;
        repeat (4) @(posedge clk_sys);
        bus(1'b0, ITT_OFS_COUNT, 32'h0);
        c0 = q;
        repeat (100) @(posedge clk_sys);
        rd(ITT_OFS_COUNT, c0);
        sys_halt <= 1'b0;
        bus(1'b1, ITT_OFS_MASK, 32'h1);
        bus(1'b0, ITT_OFS_STATUS, 32'h0);
        wait_irq(2100);
        bus(1'b0, ITT_OFS_COUNT, 32'h0);
        chk({31'h0, q < 3}, 32'h1);
        rd(ITT_OFS_STATUS, 32'h1);
        chk({31'h0, irq_o}, 32'h0);
        bus(1'b1, ITT_OFS_MASK, 32'h0);
        repeat (2100) @(posedge clk_sys);
        chk({31'h0, irq_o}, 32'h0);
        rd(ITT_OFS_STATUS, 32'h1);
        bus(1'b1, ITT_OFS_MODE, 32'hC | ($random(seed) & 3));
        repeat (300) @(posedge clk_sys);
        rd(ITT_OFS_COUNT, 32'h0);
        // Leaving the cleared state at /8: 17 edges hold two or three ticks
        bus(1'b1, ITT_OFS_MODE, 32'h7);
        repeat (16) @(posedge clk_sys);
        bus(1'b0, ITT_OFS_COUNT, 32'h0);
        chk({31'h0, q >= 32'h2 && q <= 32'h3}, 32'h1);
        bus(1'b1, ITT_OFS_MASK, 32'h1);
        for (int p = 0; p < 4; p++) begin
            bus(1'b1, ITT_OFS_MODE, 32'hC);
            @(negedge sub_clk);
            @(posedge clk_sys);
            bus(1'b1, ITT_OFS_MODE, 8 + p);
            rd(ITT_OFS_MODE, 32'hF8 + p);
            repeat (64) @(posedge sub_clk);
            repeat (10) @(posedge clk_sys);
            rd(ITT_OFS_COUNT, 32'd64 >> sub_e[p]);
        end
        wait_irq(20000);
        rd(ITT_OFS_STATUS, 32'h1);
        stop_test();
    end
endmodule : itt_timer_tb
bind itt_timer itt_timer_asserts chk_i (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o));
